// *** oass_pkg.sv ***
// Shared constants and types for the octal SAR converter serial sequencer
package oass_pkg;

  // Result and control word layout
  localparam int          CODE_W       = 12;
  localparam int          CTRL_W       = 8;
  localparam int          CH_W         = 3;
  localparam int          CH_MSB       = 5;
  localparam int          CH_LSB       = 3;
  localparam logic [2:0]  CH_DEFAULT   = 3'h0;

  // Falling-edge positions within one 16-clock conversion
  localparam int          FCNT_W       = 5;
  localparam logic [4:0]  FALL_FIRST   = 5'h01;
  localparam logic [4:0]  FALL_HOLD    = 5'h04;
  localparam logic [4:0]  FALL_DATA    = 5'h05;
  localparam logic [4:0]  FALL_LAST    = 5'h10;
  localparam logic [4:0]  FCNT_IDLE    = 5'h00;

  // Rising-edge count for the control byte
  localparam int          RCNT_W       = 4;
  localparam logic [3:0]  CTRL_RISES   = 4'h8;
  localparam logic [3:0]  RCNT_IDLE    = 4'h0;

  // Result buffer depth
  localparam int          FIFO_DEPTH   = 16;

  // Sequencer phases, Gray coded along idle-armed-track-hold-gap
  typedef enum logic [2:0] {
    OASS_IDLE  = 3'h0,
    OASS_ARMED = 3'h1,
    OASS_TRACK = 3'h3,
    OASS_HOLD  = 3'h2,
    OASS_GAP   = 3'h6
  } oass_state_t;

endpackage

// *** oass_fifo_if.sv ***
// Carrier between the sequencer and its result buffer
`timescale 1ns/10ps
interface oass_fifo_if #(
  parameter int W = 12
);
  logic [W-1:0] in_data;
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] out_data;
  logic         out_valid;
  logic         out_ready;
  logic         flush;

  modport fifo (
    input  in_data, in_valid, out_ready, flush,
    output in_ready, out_data, out_valid
  );
  modport user (
    output in_data, in_valid, out_ready, flush,
    input  in_ready, out_data, out_valid
  );
endinterface

// *** oass_fifo.sv ***
// Result FIFO between the converter core and the serial shifter
`timescale 1ns/10ps
module oass_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Buffer ports
  oass_fifo_if.fifo q
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   count_q;
  logic [AW:0]   count_d;
  logic          in_ready_q;
  logic          push;
  logic          pop;

  // Ready is its own flop so the source sees it with no gate behind it
  assign q.in_ready  = in_ready_q;
  assign q.out_valid = (count_q != '0);
  assign q.out_data  = mem[rd_q];
  assign push        = q.in_valid && in_ready_q;
  assign pop         = q.out_valid && q.out_ready;

  // Occupancy after this cycle
  always_comb begin
    count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // Pointers and occupancy; flush drops stale results
  always_ff @(posedge clock) begin
    if (reset || q.flush) begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
      in_ready_q <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      count_q <= count_d;
      in_ready_q <= (count_d != DEPTH_C);
    end
  end

  // Storage needs no reset
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= q.in_data;
    end
  end

endmodule

// *** oass_sequencer.sv ***
// Serial interface and conversion sequencer of the eight-channel SAR converter
// Operation
// (RULE1) Track for first 3 serial clocks after select falls, then hold 13.
// (RULE2) Result is 12-bit straight binary, one step is supply over 4096.
// (RULE3) Active while select low, powered down while select high.
// (RULE4) In continuous mode power down from falling edge 16 to next edge 1.
// (RULE5) Each conversion spans 16 clocks; conversions repeat while select stays low.
// (RULE6) A frame runs from select falling to select rising; conversion starts there.
// (RULE7) Host gives a multiple of 16 rising clock edges per frame.
// (RULE8) Serial output driven only while select is low.
// (RULE9) Serial clock is ignored while select is high.
// (RULE10) Falling edges 1-4 shift zeros, edges 5-16 shift the result MSB first.
// (RULE11) Back to track after each 16th rising edge, hold four falling edges later.
// (RULE12) Select falling with clock high: track from the next falling edge.
// (RULE13) Select falling with clock low: track at once, counts as edge 1.
// (RULE14) Select and clock falling together: track at once.
// (RULE15) Control bits captured on the first 8 rising edges of each conversion.
// (RULE16) Only control bits 5..3 matter, as channel address; others ignored.
// (RULE17) Captured address selects, as binary 0..7, the next conversion's input.
// (RULE18) First conversion after power-up uses channel 0, valid at full resolution.
// (RULE19) Control byte arrives MSB first: bit 7 on rise 1, bit 0 on rise 8.
`timescale 1ns/10ps
module oass_sequencer
  import oass_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset,
  // Serial pins, synchronous to clock
  input  wire logic              cs_n,
  input  wire logic              sclk,
  input  wire logic              din,
  output logic                   dout,
  output logic                   dout_oe,
  // Analog front-end control
  output logic [CH_W-1:0]        chan_sel,
  output logic                   track_en,
  output logic                   conv_start,
  output logic                   powered,
  // Results from the converter core
  input  wire logic [CODE_W-1:0] sar_code,
  input  wire logic              sar_valid,
  output logic                   sar_ready
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  oass_state_t           state_q;
  oass_state_t           state_d;
  logic                  cs_low;
  logic                  cs_low_q;
  logic                  sclk_q;
  logic                  cs_fall;
  logic                  cs_rise;
  logic                  fall_ev;
  logic                  rise_ev;
  logic                  start_now;
  logic                  new_conv;
  logic                  in_conv;
  logic [FCNT_W-1:0]     fcnt_q;
  logic [FCNT_W-1:0]     fcnt_next;
  logic [RCNT_W-1:0]     rcnt_q;
  logic [CTRL_W-1:0]     next_channel_select_q;
  logic [CTRL_W-1:0]     ctrl_w;
  logic [CH_W-1:0]       next_chan_q;
  logic [CODE_W-1:0]     shreg_q;
  logic                  load_now;
  logic                  dout_q;
  logic                  dout_oe_q;
  logic [CH_W-1:0]       chan_sel_q;
  logic                  track_q;
  logic                  conv_start_q;
  logic                  powered_q;

  oass_fifo_if #(.W(CODE_W)) res ();

  // Channel address field of a control word; other bits are don't care
  function automatic logic [CH_W-1:0] chan_of(input logic [CTRL_W-1:0] w);
    chan_of = w[CH_MSB:CH_LSB];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin history and edge events

  // One-cycle history of select and clock
  always_ff @(posedge clock) begin
    if (reset) begin
      cs_low_q <= 1'b0;
      sclk_q   <= 1'b0;
    end else begin
      cs_low_q <= cs_low;
      sclk_q   <= sclk;
    end
  end

  // Clock edges only count while select was and is low
  assign cs_low    = !cs_n;
  assign cs_fall   = cs_low && !cs_low_q;                     // [RULE6]
  assign cs_rise   = !cs_low && cs_low_q;
  assign fall_ev   = cs_low && cs_low_q && sclk_q && !sclk;   // [RULE9]
  assign rise_ev   = cs_low && cs_low_q && !sclk_q && sclk;   // [RULE9]
  assign start_now = cs_fall && !sclk;                        // [RULE13] [RULE14]
  assign in_conv   = (state_q == OASS_TRACK) || (state_q == OASS_HOLD);
  assign new_conv  = start_now
                   || (fall_ev && ((state_q == OASS_ARMED) || (state_q == OASS_GAP)));
  assign fcnt_next = fcnt_q + FALL_FIRST;

  ////////////////////////////////////////////////////////////////////////
  // Conversion phase

  // Next phase from the falling-edge position
  always_comb begin
    state_d = state_q;
    if (!cs_low) begin
      state_d = OASS_IDLE;                                    // [RULE3]
    end else if (cs_fall) begin
      state_d = start_now ? OASS_TRACK : OASS_ARMED;          // [RULE12] [RULE13]
    end else if (fall_ev) begin
      case (state_q)
        OASS_ARMED: begin
          state_d = OASS_TRACK;                               // [RULE12]
        end
        OASS_GAP: begin
          state_d = OASS_TRACK;                               // [RULE5] [RULE11]
        end
        OASS_TRACK: begin
          if (fcnt_next == FALL_HOLD) begin
            state_d = OASS_HOLD;                              // [RULE1] [RULE11]
          end
        end
        OASS_HOLD: begin
          if (fcnt_next == FALL_LAST) begin
            state_d = OASS_GAP;                               // [RULE4]
          end
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end
  end

  // Phase register and phase-derived outputs
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q   <= OASS_IDLE;
      track_q   <= 1'b0;
      powered_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      track_q   <= (state_d == OASS_TRACK);
      // Power only when a conversion is live or armed
      powered_q <= (state_d == OASS_ARMED) || (state_d == OASS_TRACK)
                || (state_d == OASS_HOLD);                    // [RULE3] [RULE4]
    end
  end

  // Falling-edge position within the conversion, 1..16
  always_ff @(posedge clock) begin
    if (reset) begin
      fcnt_q <= FCNT_IDLE;
    end else if (!cs_low) begin
      fcnt_q <= FCNT_IDLE;
    end else if (new_conv) begin
      fcnt_q <= FALL_FIRST;                                   // [RULE13] [RULE5]
    end else if (fall_ev && in_conv) begin
      fcnt_q <= fcnt_next;
    end
  end

  // Hold strobe to the converter core at the fourth falling edge
  always_ff @(posedge clock) begin
    if (reset) begin
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= fall_ev && (state_q == OASS_TRACK)
                   && (fcnt_next == FALL_HOLD);               // [RULE1]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control byte and channel selection

  // New control word with the incoming bit shifted in
  assign ctrl_w = {next_channel_select_q[CTRL_W-2:0], din};

  // Capture on rises 1..8 of each conversion; the 4-bit count wraps every 16
  // rises, which stays aligned only when frames hold whole conversions
  always_ff @(posedge clock) begin
    if (reset) begin
      rcnt_q                <= RCNT_IDLE;
      next_channel_select_q <= '0;
      next_chan_q           <= CH_DEFAULT;                    // [RULE18]
    end else if (!cs_low) begin
      rcnt_q <= RCNT_IDLE;                                    // [RULE6]
    end else if (rise_ev) begin
      rcnt_q <= rcnt_q + 1'b1;                                // [RULE7]
      if (rcnt_q < CTRL_RISES) begin
        next_channel_select_q <= ctrl_w;                      // [RULE15] [RULE19]
      end
      if (rcnt_q == CTRL_RISES - 1'b1) begin
        next_chan_q <= chan_of(ctrl_w);                       // [RULE16]
      end
    end
  end

  // Mux index switches as the next conversion starts tracking
  always_ff @(posedge clock) begin
    if (reset) begin
      chan_sel_q <= CH_DEFAULT;                               // [RULE18]
    end else if (new_conv) begin
      chan_sel_q <= next_chan_q;                              // [RULE17]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result buffer

  // Results of an aborted frame are dropped so later ones stay aligned
  assign res.in_data   = sar_code;
  assign res.in_valid  = sar_valid;
  assign res.flush     = cs_rise;
  assign load_now      = fall_ev && (state_q == OASS_HOLD) && (fcnt_next == FALL_DATA);
  assign res.out_ready = load_now;
  assign sar_ready     = res.in_ready;

  oass_fifo #(
    .W     (CODE_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock (clock),
    .reset (reset),
    .q     (res.fifo)
  );

  ////////////////////////////////////////////////////////////////////////
  // Serial output

  // Zeros on edges 1-4, then the 12-bit code MSB first; an empty buffer
  // shifts zeros rather than stalling the host clock
  always_ff @(posedge clock) begin
    if (reset) begin
      dout_q    <= 1'b0;
      dout_oe_q <= 1'b0;
      shreg_q   <= '0;
    end else begin
      dout_oe_q <= cs_low;                                    // [RULE8]
      if (!cs_low) begin
        dout_q <= 1'b0;
      end else if (new_conv) begin
        dout_q <= 1'b0;                                       // [RULE10]
      end else if (fall_ev && in_conv) begin
        if (fcnt_next < FALL_DATA) begin
          dout_q <= 1'b0;                                     // [RULE10]
        end else if (load_now) begin
          dout_q  <= res.out_valid && res.out_data[CODE_W-1]; // [RULE2]
          shreg_q <= res.out_valid ? {res.out_data[CODE_W-2:0], 1'b0} : '0;
        end else begin
          dout_q  <= shreg_q[CODE_W-1];                       // [RULE10]
          shreg_q <= {shreg_q[CODE_W-2:0], 1'b0};
        end
      end
    end
  end

  assign dout       = dout_q;
  assign dout_oe    = dout_oe_q;
  assign chan_sel   = chan_sel_q;
  assign track_en   = track_q;
  assign conv_start = conv_start_q;
  assign powered    = powered_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_fall_low;
    cs_fall && !sclk;
  endsequence

  sequence s_fall_high;
    cs_fall && sclk;
  endsequence

  sequence s_gap_fall;
    fall_ev && (state_q == OASS_GAP) ##0 cs_low;
  endsequence

  AST_OE_FOLLOWS_CS: assert property ( // [RULE8]
    cs_n |=> !dout_oe_q ##0 !dout_q)
    else $error("Serial output enabled while select high");

  AST_POWER_OFF: assert property ( // [RULE3]
    cs_n |=> !powered_q && (state_q == OASS_IDLE))
    else $error("Powered while select high");

  AST_LOW_ENTRY: assert property ( // [RULE13] [RULE14]
    s_fall_low |=> track_q && (fcnt_q == FALL_FIRST))
    else $error("No immediate tracking on select fall with clock low");

  AST_HIGH_ENTRY: assert property ( // [RULE12]
    s_fall_high ##1 (cs_low && !fall_ev)[*1] |=> (state_q == OASS_ARMED) && !track_q)
    else $error("Tracking before first falling edge");

  AST_HOLD_AT_FOUR: assert property ( // [RULE1] [RULE11]
    $rose(state_q == OASS_HOLD) |-> (fcnt_q == FALL_HOLD) && conv_start_q)
    else $error("Hold entered at wrong falling edge");

  AST_GAP_AT_SIXTEEN: assert property ( // [RULE4]
    (state_q == OASS_GAP) |-> (fcnt_q == FALL_LAST) && !powered_q)
    else $error("Power gap outside edge 16 to edge 1");

  AST_NEXT_CONV: assert property ( // [RULE5] [RULE17]
    s_gap_fall |=> track_q && (chan_sel_q == $past(next_chan_q)) && (fcnt_q == FALL_FIRST))
    else $error("Back-to-back conversion did not start");

  AST_LEAD_ZEROS: assert property ( // [RULE10]
    fall_ev && in_conv && (fcnt_next < FALL_DATA) |=> !dout_q)
    else $error("Nonzero leading bit");

  AST_CLOCK_GATED: assert property ( // [RULE9]
    cs_n && !cs_low_q |=> $stable(next_channel_select_q) && $stable(chan_sel_q))
    else $error("Clock acted while select high");

  AST_CTRL_ADDR: assert property ( // [RULE16] [RULE15]
    rise_ev && (rcnt_q == CTRL_RISES - 1'b1)
      |=> (next_chan_q == next_channel_select_q[CH_MSB:CH_LSB]) && (next_channel_select_q[0] == $past(din)))
    else $error("Channel address not taken from bits 5..3");

  AST_TRACK_SPAN: assert property ( // [RULE1]
    $fell(track_q) && cs_low_q |-> conv_start_q && (fcnt_q == FALL_HOLD))
    else $error("Tracking did not end at the fourth falling edge");

  AST_RESULT_MSB: assert property ( // [RULE10] [RULE2]
    load_now && res.out_valid |=> dout_q == $past(res.out_data[CODE_W-1]))
    else $error("Result MSB not shifted at falling edge five");

  AST_DESELECT_CLEAR: assert property ( // [RULE9] [RULE6]
    cs_n |=> (rcnt_q == RCNT_IDLE) && (fcnt_q == FCNT_IDLE))
    else $error("Edge counts kept while select high");

endmodule

// *** oass_host_model.sv ***
// Serial host model that frames conversions and shifts control bytes
`timescale 1ns/10ps
module oass_host_model #(
  parameter int H = 6
) (
  // Clock
  input  wire logic clock,
  // Serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout,
  input  wire logic dout_oe,
  // Observed converter status
  input  wire logic track_en,
  input  wire logic powered
);
  logic [7:0]  tx [0:8];
  logic [15:0] rx [0:8];

  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wait a number of system clocks
  task automatic hc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One frame of n conversions; mode 0 select falls with clock high, 1 low, 2 together
  task automatic frame(input int n, input int mode);
    int k;
    sclk <= (mode != 1);
    hc(2);
    cs_n <= 1'b0;
    if (mode == 2) sclk <= 1'b0;
    din  <= tx[0][7];
    hc(3);
    testbench.check(track_en, mode != 0, "track at select fall");
    testbench.check(powered, 1'b1, "powered while selected");
    for (k = 0; k < 16 * n; k++) begin
      if (k > 0 || mode == 0) begin
        hc(k == 0 ? H - 3 : H);
        sclk <= 1'b0;
        // Control byte MSB first, filler toggles so stale bits never look valid
        din  <= (k % 16 < 8) ? tx[k/16][7 - k % 16] : ~din;
      end
      hc((k == 0 && mode != 0) ? H - 3 : H);
      rx[k/16] <= {rx[k/16][14:0], dout};
      testbench.check(track_en, (k % 16) < 3, "track phase at rise");
      testbench.check(powered, (k % 16) != 15, "power gap at rise");
      testbench.check(dout_oe, 1'b1, "output enabled");
      sclk <= 1'b1;
    end
    // Whole conversions only, then release select and disturb the data line
    hc(H);
    cs_n <= 1'b1;
    din  <= ~din;
    hc(3);
    testbench.check(dout_oe, 1'b0, "output released");
    testbench.check(powered, 1'b0, "powered down");
  endtask

  // Clock activity while deselected
  task automatic wiggle(input int n);
    repeat (n) begin
      hc(H);
      sclk <= ~sclk;
      din  <= ~din;
    end
  endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the serial sequencer
`timescale 1ns/10ps
module testbench;
  import oass_pkg::*;

  logic              clock;
  logic              reset;
  logic              cs_n;
  logic              sclk;
  logic              din;
  logic              dout;
  logic              dout_oe;
  logic [CH_W-1:0]   chan_sel;
  logic              track_en;
  logic              conv_start;
  logic              powered;
  logic [CODE_W-1:0] sar_code;
  logic              sar_valid;
  logic              sar_ready;
  logic              core_en;
  int                n_errors;
  int                total_checks;
  int                n_conv;

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    sar_code = 12'h000;
    sar_valid = 1'b0;
    core_en = 1'b0;
    n_errors = 0;
    total_checks = 0;
    n_conv = 0;
  end

  // Clock at 200 MHz
  always #2.5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  // Shallow buffer so that full and empty are reached quickly
  oass_sequencer #(.DEPTH(2)) i_dut (
    .clock(clock), .reset(reset), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
    .dout_oe(dout_oe), .chan_sel(chan_sel), .track_en(track_en), .conv_start(conv_start),
    .powered(powered), .sar_code(sar_code), .sar_valid(sar_valid), .sar_ready(sar_ready)
  );

  oass_host_model #(.H(6)) i_host (
    .clock(clock), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
    .track_en(track_en), .powered(powered)
  );

  // Core model: one code per conversion, channel encoded in the top bits
  always @(posedge clock) begin
    if (core_en) begin
      sar_valid <= (conv_start === 1'b1);
      sar_code  <= {chan_sel, 9'h0a5};
    end
  end

  // Count hold entries
  always @(posedge clock) begin
    if (conv_start === 1'b1) n_conv++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic push(input logic [11:0] w);
    @(posedge clock);
    sar_valid <= 1'b1;
    sar_code  <= w;
  endtask

  task automatic t_reset;
    check({dout_oe, powered, track_en, dout}, 4'h0, "idle outputs");
    check(chan_sel, 3'h0, "power-up channel");
    check(sar_ready, 1'b1, "buffer empty");
    $display("t_reset done");
  endtask

  // Nine conversions in one frame, every address, noisy ignored bits
  task automatic t_channels;
    int k;
    for (k = 0; k < 9; k++) i_host.tx[k] = {k[1:0], 3'(7 - k), ~k[2:0]};
    core_en = 1'b1;
    n_conv = 0;
    i_host.frame(9, 0);
    check(n_conv, 9, "conversions in frame");
    for (k = 0; k < 9; k++)
      check(i_host.rx[k], {4'h0, 3'(k == 0 ? 0 : 8 - k), 9'h0a5}, "result word");
    $display("t_channels done");
  endtask

  // Each select-fall case; deselected clocks must not disturb anything
  task automatic t_modes;
    int m;
    int prev;
    prev = 7;
    i_host.wiggle(6);
    check({track_en, powered, dout_oe}, 3'h0, "clock gated while deselected");
    for (m = 0; m < 3; m++) begin
      i_host.tx[0] = {2'b01, 3'(m + 1), 3'b010};
      i_host.tx[1] = {2'b10, 3'(m + 4), 3'b101};
      n_conv = 0;
      i_host.frame(2, m);
      check(n_conv, 2, "conversions in frame");
      check(i_host.rx[0], {4'h0, 3'(prev), 9'h0a5}, "first word");
      check(i_host.rx[1], {4'h0, 3'(m + 1), 9'h0a5}, "second word");
      prev = m + 4;
    end
    $display("t_modes done");
  endtask

  // Fill to refusal, drain past empty, flush on deselect
  task automatic t_buffer;
    core_en = 1'b0;
    push(12'h3c0);
    push(12'h3c1);
    @(posedge clock);
    sar_valid <= 1'b0;
    repeat (2) @(posedge clock);
    check(sar_ready, 1'b0, "buffer full");
    push(12'hfff);
    push(12'hfff);
    @(posedge clock);
    sar_valid <= 1'b0;
    i_host.frame(3, 0);
    check(i_host.rx[0], 16'h03c0, "oldest word");
    check(i_host.rx[1], 16'h03c1, "next word");
    check(i_host.rx[2], 16'h0000, "empty gives zeros");
    check(sar_ready, 1'b1, "room again");
    push(12'h2a4);
    push(12'h2a5);
    @(posedge clock);
    sar_valid <= 1'b0;
    i_host.frame(1, 1);
    check(i_host.rx[0], 16'h02a4, "word before flush");
    i_host.frame(1, 0);
    check(i_host.rx[0], 16'h0000, "flushed on deselect");
    $display("t_buffer done");
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    t_reset;
    t_channels;
    t_modes;
    t_buffer;
    end_of_test;
  end

  // Watchdog, about six times the expected run
  initial begin
    repeat (25000) @(posedge clock);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test;
  end
endmodule
